// ### common/i2c_ack_flags_defs.svh
// Register offsets, bit positions and frame counts of the acknowledge and flag block.
`ifndef I2C_ACK_FLAGS_DEFS_SVH
`define I2C_ACK_FLAGS_DEFS_SVH
`define OFS_IER      8'h00
`define OFS_SR       8'h04
`define OFS_TXH      8'h08
`define OFS_RXH      8'h0C
`define OFS_CTL      8'h10
`define OFS_IST      8'h14
`define OFS_IMSK     8'h18
`define REG_RST      8'h00
`define BIT_RST      1'h0
`define IER_STOP_EN  3
`define IER_JUDGE    2
`define IER_ACK_RX   1
`define IER_ACK_TX   0
`define CTL_TX_MODE  0
`define CTL_BUSY     1
`define CTL_SYNC     2
`define CTL_HALTED   3
`define SR_FLAG_LSB  3
`define FL_N         5
`define FL_STOP      0
`define FL_NACK      1
`define FL_RXF       2
`define FL_TXD       3
`define FL_TXE       4
`define HTRANS_ACT   1
`define CNT_ZERO     4'h0
`define CNT_ONE      4'h1
`define LAST_BIT     4'h7
`define DATA_BITS    4'h8
`define ACK_SLOT     4'h9
`endif

// ### common/i2c_ack_flags_pkg.sv
// Types shared by the acknowledge and flag block.
`default_nettype none
package i2c_ack_flags_pkg;
  typedef enum logic [3:0] {
    LS_IDLE = 4'h1,
    LS_DATA = 4'h2,
    LS_ACK  = 4'h4,
    LS_HALT = 4'h8
  } link_state_type;
endpackage
`default_nettype wire

// ### rtl/sync3.sv
// Three-stage synchroniser with agreement filter for a level from outside hclk.
`timescale 1ns/1ps
`default_nettype none
module sync3
#(
  parameter logic INIT = 1'h1
)
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic din,
  output var  logic dout_r
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // The first stage is seen by the second only; stages two and three must agree.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_r   <= INIT;
      s2_r   <= INIT;
      s3_r   <= INIT;
      dout_r <= INIT;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        dout_r <= s3_r;
    end
  end
endmodule
`default_nettype wire

// ### rtl/flag_cell.sv
// One status flag: hardware set, read-one-then-write-zero clear, hardware clear.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_ack_flags_defs.svh"
module flag_cell
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic set_evt,
  input  wire logic hw_clr,
  input  wire logic sw_rd,
  input  wire logic sw_wr,
  input  wire logic wr_bit,
  output var  logic flag_r
);
  logic armed_r;
  logic clr;

  assign clr = hw_clr || (sw_wr && !wr_bit && armed_r);

  // A set in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flag_r <= `BIT_RST;
    else if (set_evt)
      flag_r <= 1'h1;
    else if (clr)
      flag_r <= 1'h0;
  end

  // Only a read that returned one arms the clear; a write disarms it unless a status read comes in the same cycle.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      armed_r <= `BIT_RST;
    else if (sw_rd)
      armed_r <= flag_r;
    else if (sw_wr || !flag_r)
      armed_r <= 1'h0;
  end
endmodule
`default_nettype wire

// ### rtl/i2c_ack_flags.sv
// AHB-Lite slave with acknowledge control and transfer status flags of a two-wire link.
//
// Operation
// - Stop request only when enabled and flagged.
// - Judge off: ignore acknowledge, keep transferring.
// - Judge on and acknowledge high: halt.
// - Transmit: capture returned acknowledge, read-only.
// - Busy flag clearing clears captured acknowledge.
// - Receive: drive transmit acknowledge in slot.
// - Reset clears status register to zero.
// - Set transmit-empty on move, mode, start.
// - Transmit-empty clears by read-zero or write.
// - Ninth clock rise with empty sets end.
// - Synchronous format: last bit sets end.
// - Transmit-end clears by read-zero or write.
// - Byte into receive holding sets full.
// - Receive-full clears by read-zero or read.
// - Reset clears enable and acknowledge register.
// - Missing acknowledge while judging sets flag.
// - Stop after a frame sets stop flag.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_ack_flags_defs.svh"
module i2c_ack_flags
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output var  logic        sda_out,
  output var  logic        sda_oe,
  output var  logic        irq,
  output var  logic        stop_irq_request
);
  i2c_ack_flags_pkg::link_state_type state_r;
  logic [7:0]       dp_addr_r;
  logic             dp_wr_r;
  logic             ap;
  logic             rd_ap;
  logic             sr_rd;
  logic             rx_rd;
  logic             wr_ier;
  logic             wr_sr;
  logic             wr_txh;
  logic             wr_ctl;
  logic             wr_ist;
  logic             wr_imsk;
  logic [7:0]       rd_byte;
  logic             stop_irq_enable_r;
  logic             judge_r;
  logic             ack_transmit_bit_r;
  logic             ack_rx_r;
  logic             tx_mode_r;
  logic             sync_r;
  logic             busy_r;
  logic             busy_nxt;
  logic             busy_fall;
  logic [7:0]       tx_hold_r;
  logic             tx_full_r;
  logic [7:0]       rx_hold_r;
  logic [7:0]       shift_r;
  logic [7:0]       load_byte;
  logic [3:0]       cnt_r;
  logic             frame_r;
  logic             scl_q;
  logic             sda_q;
  logic             scl_d;
  logic             sda_d;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_det;
  logic             stop_det;
  logic             load_evt;
  logic             mv_evt;
  logic             bit_done;
  logic             ack_rise;
  logic             ack_cap;
  logic             nack_hit;
  logic             txm_rise;
  logic [`FL_N-1:0] ev;
  logic [`FL_N-1:0] hw_clr;
  logic [`FL_N-1:0] flags;
  logic [`FL_N-1:0] ist_r;
  logic [`FL_N-1:0] imsk_r;

  // Bus side: zero wait states, every access answers OKAY.
  assign ap      = hsel && hready && htrans[`HTRANS_ACT];
  assign rd_ap   = ap && !hwrite;
  assign sr_rd   = rd_ap && (haddr[7:0] == `OFS_SR);
  assign rx_rd   = rd_ap && (haddr[7:0] == `OFS_RXH);
  assign wr_ier  = dp_wr_r && (dp_addr_r == `OFS_IER);
  assign wr_sr   = dp_wr_r && (dp_addr_r == `OFS_SR);
  assign wr_txh  = dp_wr_r && (dp_addr_r == `OFS_TXH);
  assign wr_ctl  = dp_wr_r && (dp_addr_r == `OFS_CTL);
  assign wr_ist  = dp_wr_r && (dp_addr_r == `OFS_IST);
  assign wr_imsk = dp_wr_r && (dp_addr_r == `OFS_IMSK);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr_r   <= `BIT_RST;
      dp_addr_r <= `REG_RST;
      hreadyout <= 1'h1;
      hresp     <= `BIT_RST;
      sda_out   <= `BIT_RST;
    end
    else
    begin
      dp_wr_r   <= ap && hwrite;
      dp_addr_r <= haddr[7:0];
      hreadyout <= 1'h1;
      hresp     <= `BIT_RST;
      sda_out   <= `BIT_RST;
    end
  end

  always_comb
  begin
    rd_byte = `REG_RST;
    if (haddr[7:0] == `OFS_IER)
      rd_byte = {4'h0, stop_irq_enable_r, judge_r, ack_rx_r, ack_transmit_bit_r};
    else if (haddr[7:0] == `OFS_SR)
      rd_byte = {flags, 3'h0};
    else if (haddr[7:0] == `OFS_TXH)
      rd_byte = tx_hold_r;
    else if (haddr[7:0] == `OFS_RXH)
      rd_byte = rx_hold_r;
    else if (haddr[7:0] == `OFS_CTL)
      rd_byte = {4'h0, state_r == i2c_ack_flags_pkg::LS_HALT, sync_r, busy_r, tx_mode_r};
    else if (haddr[7:0] == `OFS_IST)
      rd_byte = {3'h0, ist_r};
    else if (haddr[7:0] == `OFS_IMSK)
      rd_byte = {3'h0, imsk_r};
  end

  // Read data is fetched at the address phase so it stands through the data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0;
    else if (rd_ap)
      hrdata <= {24'h0, rd_byte};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stop_irq_enable_r  <= `BIT_RST;
      judge_r <= `BIT_RST;
      ack_transmit_bit_r <= `BIT_RST;
    end
    else if (wr_ier)
    begin
      stop_irq_enable_r  <= hwdata[`IER_STOP_EN];
      judge_r <= hwdata[`IER_JUDGE];
      ack_transmit_bit_r <= hwdata[`IER_ACK_TX];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ack_rx_r <= `BIT_RST;
    else if (ack_cap)
      ack_rx_r <= sda_q;
    else if (busy_fall)
      ack_rx_r <= 1'h0;
  end

  // A start sets busy and a stop clears it; either beats a software write.
  always_comb
  begin
    busy_nxt = busy_r;
    if (start_det)
      busy_nxt = 1'h1;
    else if (stop_det)
      busy_nxt = 1'h0;
    else if (wr_ctl)
      busy_nxt = hwdata[`CTL_BUSY];
  end
  assign busy_fall = busy_r && !busy_nxt;
  assign txm_rise  = wr_ctl && hwdata[`CTL_TX_MODE] && !tx_mode_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy_r    <= `BIT_RST;
      tx_mode_r <= `BIT_RST;
      sync_r    <= `BIT_RST;
    end
    else
    begin
      busy_r <= busy_nxt;
      if (wr_ctl)
      begin
        tx_mode_r <= hwdata[`CTL_TX_MODE];
        sync_r    <= hwdata[`CTL_SYNC];
      end
    end
  end

  // A fresh write beats a same-cycle move, so the new byte is never dropped.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_hold_r <= `REG_RST;
      tx_full_r <= `BIT_RST;
    end
    else if (wr_txh)
    begin
      tx_hold_r <= hwdata[7:0];
      tx_full_r <= 1'h1;
    end
    else if (mv_evt)
      tx_full_r <= 1'h0;
  end

  sync3 #(.INIT(1'h1)) u_scl (.hclk(hclk), .hresetn(hresetn), .din(scl_in), .dout_r(scl_q));
  sync3 #(.INIT(1'h1)) u_sda (.hclk(hclk), .hresetn(hresetn), .din(sda_in), .dout_r(sda_q));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scl_d <= 1'h1;
      sda_d <= 1'h1;
    end
    else
    begin
      scl_d <= scl_q;
      sda_d <= sda_q;
    end
  end

  assign scl_rise  = scl_q && !scl_d;
  assign scl_fall  = !scl_q && scl_d;
  assign start_det = !sync_r && scl_q && scl_d && sda_d && !sda_q;
  assign stop_det  = !sync_r && scl_q && scl_d && !sda_d && sda_q;
  assign load_evt  = scl_fall && (((state_r == i2c_ack_flags_pkg::LS_DATA) && (cnt_r == `CNT_ZERO))
                  || ((state_r == i2c_ack_flags_pkg::LS_ACK) && (cnt_r == `ACK_SLOT))
                  || ((state_r == i2c_ack_flags_pkg::LS_IDLE) && sync_r));
  assign mv_evt    = load_evt && tx_mode_r && tx_full_r;
  assign load_byte = (tx_mode_r && tx_full_r) ? tx_hold_r : shift_r;
  assign bit_done  = scl_rise && (state_r == i2c_ack_flags_pkg::LS_DATA) && (cnt_r == `LAST_BIT);
  assign ack_rise  = scl_rise && (state_r == i2c_ack_flags_pkg::LS_ACK) && (cnt_r == `DATA_BITS);
  assign ack_cap   = ack_rise && tx_mode_r;
  assign nack_hit  = ack_cap && judge_r && sda_q;

  // Without a byte waiting the old shift contents go out again; clock stretching is not done.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= i2c_ack_flags_pkg::LS_IDLE;
      cnt_r   <= `CNT_ZERO;
      shift_r <= `REG_RST;
      sda_oe  <= `BIT_RST;
    end
    else if (start_det)
    begin
      state_r <= i2c_ack_flags_pkg::LS_DATA;
      cnt_r   <= `CNT_ZERO;
      sda_oe  <= 1'h0;
    end
    else if (stop_det)
    begin
      state_r <= i2c_ack_flags_pkg::LS_IDLE;
      sda_oe  <= 1'h0;
    end
    else
    begin
      case (state_r)
        i2c_ack_flags_pkg::LS_IDLE:
        begin
          if (load_evt)
          begin
            state_r <= i2c_ack_flags_pkg::LS_DATA;
            cnt_r   <= `CNT_ZERO;
            shift_r <= load_byte;
            sda_oe  <= tx_mode_r && !load_byte[7];
          end
        end
        i2c_ack_flags_pkg::LS_DATA:
        begin
          if (scl_rise)
          begin
            cnt_r <= (sync_r && cnt_r == `LAST_BIT) ? `CNT_ZERO : cnt_r + `CNT_ONE;
            if (!tx_mode_r)
              shift_r <= {shift_r[6:0], sda_q};
          end
          else if (load_evt)
          begin
            shift_r <= load_byte;
            sda_oe  <= tx_mode_r && !load_byte[7];
          end
          else if (scl_fall && cnt_r == `DATA_BITS)
          begin
            state_r <= i2c_ack_flags_pkg::LS_ACK;
            sda_oe  <= !tx_mode_r && !ack_transmit_bit_r;
          end
          else if (scl_fall && tx_mode_r)
          begin
            shift_r <= {shift_r[6:0], 1'h0};
            sda_oe  <= !shift_r[6];
          end
        end
        i2c_ack_flags_pkg::LS_ACK:
        begin
          if (scl_rise)
          begin
            cnt_r <= `ACK_SLOT;
            if (nack_hit)
            begin
              state_r <= i2c_ack_flags_pkg::LS_HALT;
              sda_oe  <= 1'h0;
            end
          end
          else if (load_evt)
          begin
            state_r <= i2c_ack_flags_pkg::LS_DATA;
            cnt_r   <= `CNT_ZERO;
            shift_r <= load_byte;
            sda_oe  <= tx_mode_r && !load_byte[7];
          end
          else if (cnt_r == `DATA_BITS)
            sda_oe <= !tx_mode_r && !ack_transmit_bit_r;
        end
        i2c_ack_flags_pkg::LS_HALT:
          sda_oe <= 1'h0;
        default:
          state_r <= i2c_ack_flags_pkg::LS_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rx_hold_r <= `REG_RST;
    else if (bit_done && !tx_mode_r)
      rx_hold_r <= {shift_r[6:0], sda_q};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      frame_r <= `BIT_RST;
    else if (stop_det)
      frame_r <= 1'h0;
    else if (bit_done)
      frame_r <= 1'h1;
  end

  assign ev[`FL_STOP] = stop_det && frame_r;
  assign ev[`FL_NACK] = nack_hit;
  assign ev[`FL_RXF]  = bit_done && !tx_mode_r;
  assign ev[`FL_TXD]  = (ack_rise && flags[`FL_TXE]) || (bit_done && sync_r && tx_mode_r);
  assign ev[`FL_TXE]  = mv_evt || txm_rise || start_det;
  assign hw_clr[`FL_STOP] = 1'h0;
  assign hw_clr[`FL_NACK] = 1'h0;
  assign hw_clr[`FL_RXF]  = rx_rd;
  assign hw_clr[`FL_TXD]  = wr_txh;
  assign hw_clr[`FL_TXE]  = wr_txh;

  genvar gi;
  generate
    for (gi = 0; gi < `FL_N; gi = gi + 1)
    begin : g_flag
      flag_cell u_flag (
        .hclk    (hclk),
        .hresetn (hresetn),
        .set_evt (ev[gi]),
        .hw_clr  (hw_clr[gi]),
        .sw_rd   (sr_rd),
        .sw_wr   (wr_sr),
        .wr_bit  (hwdata[`SR_FLAG_LSB + gi]),
        .flag_r  (flags[gi])
      );
    end
  endgenerate

  // Event status is write-one-to-clear; a new event in the same cycle stays set.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ist_r            <= 5'h00;
      imsk_r           <= 5'h00;
      irq              <= `BIT_RST;
      stop_irq_request <= `BIT_RST;
    end
    else
    begin
      ist_r <= (ist_r & ~(wr_ist ? hwdata[`FL_N-1:0] : 5'h00)) | ev;
      if (wr_imsk)
        imsk_r <= hwdata[`FL_N-1:0];
      irq <= |(ist_r & imsk_r);
      stop_irq_request <= stop_irq_enable_r && flags[`FL_STOP];
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_stop_req;
    stop_irq_request == ($past(stop_irq_enable_r) && $past(flags[`FL_STOP]));
  endproperty
  a_stop_req: assert property (p_stop_req) else $error("stop request mismatch");
  property p_ack_ignore;
    ack_rise && tx_mode_r && !judge_r |=> state_r != i2c_ack_flags_pkg::LS_HALT;
  endproperty
  a_ack_ignore: assert property (p_ack_ignore) else $error("halted with judge off");
  property p_ack_halt;
    ack_rise && tx_mode_r && judge_r && sda_q |=> state_r == i2c_ack_flags_pkg::LS_HALT
      ##1 !sda_oe;
  endproperty
  a_ack_halt: assert property (p_ack_halt) else $error("no halt on nack");
  property p_ack_ro;
    wr_ier && !ack_cap && !busy_fall |=> $stable(ack_rx_r);
  endproperty
  a_ack_ro: assert property (p_ack_ro) else $error("ack bit changed by write");
  property p_ack_clr;
    busy_fall && !ack_cap |=> !ack_rx_r && !busy_r;
  endproperty
  a_ack_clr: assert property (p_ack_clr) else $error("ack bit kept after busy");
  property p_ack_drive;
    state_r == i2c_ack_flags_pkg::LS_ACK && !tx_mode_r && cnt_r == `DATA_BITS
      && $past(state_r) == i2c_ack_flags_pkg::LS_ACK |-> sda_oe == !$past(ack_transmit_bit_r);
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("wrong ack driven");
  property p_txe_set;
    mv_evt || txm_rise |=> flags[`FL_TXE];
  endproperty
  a_txe_set: assert property (p_txe_set) else $error("empty flag not set");
  property p_txe_wr;
    wr_txh && !ev[`FL_TXE] && !ev[`FL_TXD] |=> !flags[`FL_TXE] && !flags[`FL_TXD];
  endproperty
  a_txe_wr: assert property (p_txe_wr) else $error("flags kept after write");
  property p_tx_done;
    ack_rise && flags[`FL_TXE] |=> flags[`FL_TXD];
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("end flag not set");
  property p_rx_full;
    bit_done && !tx_mode_r |=> flags[`FL_RXF] && rx_hold_r[7:1] == $past(shift_r[6:0])
      && rx_hold_r[0] == $past(sda_q);
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("receive byte lost");
  property p_rx_rd;
    rx_rd && !ev[`FL_RXF] |=> !flags[`FL_RXF];
  endproperty
  a_rx_rd: assert property (p_rx_rd) else $error("full kept after read");
  property p_nack;
    nack_hit |=> flags[`FL_NACK] ##1 flags[`FL_NACK];
  endproperty
  a_nack: assert property (p_nack) else $error("nack flag not set");
  property p_w1_keep;
    wr_sr && (&hwdata[7:3]) && ev == 5'h00 && !wr_txh && !rx_rd |=> $stable(flags);
  endproperty
  a_w1_keep: assert property (p_w1_keep) else $error("flag changed by one");

  c_halt: cover property (state_r == i2c_ack_flags_pkg::LS_HALT);
  c_rx_byte: cover property (bit_done && !tx_mode_r ##[1:400] rx_rd);
  c_stop_irq: cover property (stop_irq_request && irq);
endmodule
`default_nettype wire

// ### bench/i2c_peer.sv
// Two-wire bus peer that clocks frames, sends bytes and answers acknowledges.
`timescale 1ns/1ps
`default_nettype none
module i2c_peer
(
  input  wire logic sda_line,
  output var  logic scl_o,
  output var  logic sda_o
);
  // The bit period is 320 ns. The block answers a fall only about five hclk
  // cycles later, so the low phase is the longer one; data moving while SCL is
  // high would look like a start or a stop.
  localparam int LOW_NS   = 230;
  localparam int HIGH_NS  = 90;
  localparam int SETUP_NS = 50;
  initial
  begin
    scl_o = 1'h1;
    sda_o = 1'h1;
  end
  // The short lead-in keeps the start and the first SCL fall off the hclk rising edges.
  task automatic start(input logic sync);
    #10;
    if (!sync)
      sda_o = 1'h0;
    #(HIGH_NS);
    scl_o = 1'h0;
  endtask
  task automatic stop();
    #(SETUP_NS);
    sda_o = 1'h0;
    #(LOW_NS - SETUP_NS);
    scl_o = 1'h1;
    #(HIGH_NS);
    sda_o = 1'h1;
    #(HIGH_NS);
  endtask
  task automatic bit_x(input logic b, output logic s);
    #(SETUP_NS);
    sda_o = b;
    #(LOW_NS - SETUP_NS);
    scl_o = 1'h1;
    #(HIGH_NS - 10);
    s = sda_line;
    #10;
    scl_o = 1'h0;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack, input logic slot,
                      output logic [7:0] rx, output logic ack_seen);
    logic s;
    ack_seen = 1'h1;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(tx[i], s);
      rx[i] = s;
    end
    if (slot)
      bit_x(ack, ack_seen);
  endtask
endmodule
`default_nettype wire

// ### bench/tb_i2c_ack_flags.sv
// Self-checking bench of the acknowledge and status flag block.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_ack_flags_defs.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_i2c_ack_flags;
  logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'h0000CF13;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, sda_out, sda_oe, irq, stop_irq_request, scl, sda_p;
  wire         sda_line;
  int          miscompares = 0;
  int          cmp_count = 0;
  // Open drain with pull-up: the line is low while any party pulls it.
  assign sda_line = sda_p & ~(sda_oe & ~sda_out);
  i2c_ack_flags dut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq),
    .stop_irq_request(stop_irq_request)
  );
  i2c_peer peer (.sda_line(sda_line), .scl_o(scl), .sda_o(sda_p));
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  // Only the two enables and the transmit acknowledge take a write.
  function automatic logic [7:0] exp_ier(input logic [7:0] w);
    return w & 8'h0D;
  endfunction
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_ready();
    int n = 0;
    do
      @(posedge hclk);
    while (hreadyout !== 1'h1 && ++n < 64);
    if (n >= 64)
    begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                     output logic [7:0] rd);
    @(posedge hclk);
    hsel   <= 1'h1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_ready();
    rd = hrdata[7:0];
    `CHK("hresp", 1'h0, hresp)
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] t;
    bus(1'h1, a, d, t);
  endtask
  task automatic chk_reg(input string nm, input logic [7:0] a, input logic [7:0] e,
                         input logic [7:0] m = 8'hFF);
    logic [7:0] v;
    bus(1'h0, a, 8'h00, v);
    `CHK(nm, e, v & m)
  endtask
  task automatic settle();
    repeat (3) @(posedge hclk);
    #1;
  endtask
  initial
  begin
    forever #20 hclk = ~hclk;
  end
  initial
  begin
    logic [7:0] d, e, rx;
    logic       ak;
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    `CHK("stop_req", 1'h0, stop_irq_request)
    chk_reg("ier_rst", `OFS_IER, 8'h00);
    chk_reg("sr_rst", `OFS_SR, 8'h00);
    repeat (4)
    begin
      d = rnd();
      wr(`OFS_IER, d);
      chk_reg("ier_rw", `OFS_IER, exp_ier(d));
    end
    chk_reg("unmapped", 8'h1C, 8'h00);
    $display("test registers done");
    wr(`OFS_IER, 8'h00);
    wr(`OFS_CTL, 8'h01);
    chk_reg("txe_mode", `OFS_SR, 8'h80);
    d = rnd();
    wr(`OFS_TXH, d);
    chk_reg("txe_wr", `OFS_SR, 8'h00);
    // With bit 0 set the stale shift contents resent after this byte start with a one,
    // so the line stays released for the stop.
    e = rnd() | 8'h01;
    peer.start(1'h0);
    fork
      peer.xfer(8'hFF, 1'h0, 1'h1, rx, ak);
      begin
        #1000;
        chk_reg("txe_load", `OFS_SR, 8'h80);
        wr(`OFS_TXH, e);
      end
    join
    #400;
    `CHK("byte1", d, rx)
    chk_reg("no_end", `OFS_SR, 8'h80);
    peer.xfer(8'hFF, 1'h1, 1'h1, rx, ak);
    #400;
    `CHK("byte2", e, rx)
    chk_reg("end_set", `OFS_SR, 8'hC0);
    chk_reg("ack1", `OFS_IER, 8'h02);
    wr(`OFS_IER, 8'h00);
    chk_reg("ack_ro", `OFS_IER, 8'h02);
    wr(`OFS_CTL, 8'h01);
    chk_reg("ack_busy", `OFS_IER, 8'h00);
    peer.stop();
    settle();
    chk_reg("stop_set", `OFS_SR, 8'hC8);
    wr(`OFS_SR, 8'hFF);
    wr(`OFS_SR, 8'h00);
    chk_reg("sr_keep", `OFS_SR, 8'hC8);
    wr(`OFS_SR, 8'h88);
    chk_reg("end_clr", `OFS_SR, 8'h88);
    `CHK("stop_off", 1'h0, stop_irq_request)
    wr(`OFS_IER, 8'h08);
    settle();
    `CHK("stop_on", 1'h1, stop_irq_request)
    wr(`OFS_IMSK, 8'h00);
    settle();
    `CHK("irq_mask", 1'h0, irq)
    wr(`OFS_IMSK, 8'h01);
    settle();
    `CHK("irq_on", 1'h1, irq)
    wr(`OFS_IST, 8'h01);
    settle();
    `CHK("irq_clr", 1'h0, irq)
    wr(`OFS_SR, 8'h00);
    settle();
    `CHK("stop_clr", 1'h0, stop_irq_request)
    chk_reg("sr_clr", `OFS_SR, 8'h00);
    $display("test transmit done");
    wr(`OFS_IER, 8'h04);
    d = rnd();
    wr(`OFS_TXH, d);
    peer.start(1'h0);
    peer.xfer(8'hFF, 1'h1, 1'h1, rx, ak);
    #400;
    `CHK("byte3", d, rx)
    chk_reg("halted", `OFS_CTL, 8'h08, 8'h08);
    chk_reg("nack", `OFS_SR, 8'h10, 8'h10);
    peer.xfer(8'hFF, 1'h1, 1'h1, rx, ak);
    `CHK("released", 8'hFF, rx)
    peer.stop();
    wr(`OFS_SR, 8'h00);
    $display("test judge done");
    wr(`OFS_CTL, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      wr(`OFS_IER, {7'h0, k[0]});
      d = rnd();
      peer.start(1'h0);
      peer.xfer(d, 1'h1, 1'h1, rx, ak);
      `CHK("ack_out", k[0], ak)
      chk_reg("rx_full", `OFS_SR, 8'h20, 8'h20);
      chk_reg("rx_data", `OFS_RXH, d);
      chk_reg("rx_read", `OFS_SR, 8'h00, 8'h20);
      peer.stop();
    end
    $display("test receive done");
    wr(`OFS_CTL, 8'h05);
    d = rnd();
    wr(`OFS_TXH, d);
    peer.start(1'h1);
    peer.xfer(8'hFF, 1'h0, 1'h0, rx, ak);
    #400;
    `CHK("sync_byte", d, rx)
    `CHK("sda_out", 1'h0, sda_out)
    chk_reg("sync_end", `OFS_SR, 8'h40, 8'h40);
    peer.stop();
    $display("test sync done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
